// [mcs_sequencer.v]
// Measurement command sequencer: scheduling, result capture and cell limit flags
`timescale 1ns/10ps
`include "mcs_defines.vh"

module mcs_sequencer
#(
  parameter CYC_PER_US = `MCS_NS_PER_US / `MCS_CLK_PERIOD_NS
)
(
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // Command from the serial command decoder
  input  wire        cmd_valid,
  input  wire [1:0]  cmd_kind,
  input  wire [2:0]  cmd_mode,
  input  wire [3:0]  cmd_sel,
  // Configuration group A thresholds and group B path select
  input  wire [15:0] uv_threshold,
  input  wire [15:0] ov_threshold,
  input  wire [1:0]  redundancy_path_select,
  // Converter request and answer
  output reg         conv_req_q,
  output reg  [1:0]  conv_unit_q,
  output reg  [4:0]  conv_chan_q,
  output reg  [2:0]  conv_mode_q,
  output reg         conv_redundant_q,
  input  wire        conv_ack,
  input  wire [16:0] conv_raw,
  // Result register update
  output reg         result_valid_q,
  output reg  [4:0]  result_chan_q,
  output reg  [15:0] result_data_q,
  // Status
  output reg         busy_q,
  output reg         done_q,
  output reg  [17:0] ov_flags_q,
  output reg  [17:0] uv_flags_q
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_ISSUE = 4'b0010;
  localparam ST_WAIT  = 4'b0100;
  localparam ST_HOLD  = 4'b1000;

  // Total time of a command in microseconds
  function [`MCS_US_W-1:0] total_us;
    input [1:0] kind;
    input [2:0] mode;
    input [3:0] sel;
    reg   [1:0] tab;
    begin
      // Single auxiliary and reference conversions share the three-cell times
      tab = (kind == `MCS_KIND_CELLS_AUX) ? 2'h2 :
            (((kind != `MCS_KIND_CELLS3) && (sel == `MCS_SEL_ALL)) ? 2'h1 : 2'h0);
      case (mode)
        3'h0: total_us = (tab == 2'h2) ? `MCS_T8C_M0 : ((tab == 2'h1) ? `MCS_T10C_M0 : `MCS_T1C_M0);
        3'h1: total_us = (tab == 2'h2) ? `MCS_T8C_M1 : ((tab == 2'h1) ? `MCS_T10C_M1 : `MCS_T1C_M1);
        3'h2: total_us = (tab == 2'h2) ? `MCS_T8C_M2 : ((tab == 2'h1) ? `MCS_T10C_M2 : `MCS_T1C_M2);
        3'h3: total_us = (tab == 2'h2) ? `MCS_T8C_M3 : ((tab == 2'h1) ? `MCS_T10C_M3 : `MCS_T1C_M3);
        3'h4: total_us = (tab == 2'h2) ? `MCS_T8C_M4 : ((tab == 2'h1) ? `MCS_T10C_M4 : `MCS_T1C_M4);
        3'h5: total_us = (tab == 2'h2) ? `MCS_T8C_M5 : ((tab == 2'h1) ? `MCS_T10C_M5 : `MCS_T1C_M5);
        3'h6: total_us = (tab == 2'h2) ? `MCS_T8C_M6 : ((tab == 2'h1) ? `MCS_T10C_M6 : `MCS_T1C_M6);
        3'h7: total_us = (tab == 2'h2) ? `MCS_T8C_M7 : ((tab == 2'h1) ? `MCS_T10C_M7 : `MCS_T1C_M7);
        default: total_us = `MCS_T1C_M0;
      endcase
    end
  endfunction

  // Number of conversions in a command
  function [4:0] step_count;
    input [1:0] kind;
    input [3:0] sel;
    begin
      case (kind)
        `MCS_KIND_CELLS3:    step_count = `MCS_STEPS_CELLS3;
        `MCS_KIND_CELLS_AUX: step_count = `MCS_STEPS_CELLS_AUX;
        default:             step_count = (sel == `MCS_SEL_ALL) ? `MCS_STEPS_AUX_ALL : `MCS_STEPS_AUX_ONE;
      endcase
    end
  endfunction

  // Converter and channel of a step, as {unit, channel}; worked at eight bits so no sum wraps
  function [6:0] step_target;
    input [1:0] kind;
    input [3:0] sel;
    input [4:0] step;
    reg   [7:0] idx8;
    reg   [7:0] unit8;
    reg   [7:0] chan8;
    begin
      idx8  = {3'h0, step};
      unit8 = 8'h00;
      chan8 = 8'h00;
      case (kind)
        // Three cells, one per converter, six apart
        `MCS_KIND_CELLS3:
          chan8 = {5'h00, sel[2:0]} + idx8 * {3'h0, `MCS_CELLS_PER_UNIT};
        // Cells in triples over the three converters, inputs one and two in the middle
        `MCS_KIND_CELLS_AUX:
        begin
          if ((step == `MCS_AUX_SLOT) || (step == `MCS_AUX_SLOT + 5'h01))
            chan8 = {3'h0, `MCS_CH_GPIO1} + idx8 - {3'h0, `MCS_AUX_SLOT};
          else
          begin
            if (step > `MCS_AUX_SLOT)
              idx8 = idx8 - 8'h02;
            unit8 = idx8 % {3'h0, `MCS_UNITS};
            chan8 = idx8 / {3'h0, `MCS_UNITS} + unit8 * {3'h0, `MCS_CELLS_PER_UNIT};
          end
        end
        // Auxiliary scans all run on the first converter
        default:
        begin
          if (sel == `MCS_SEL_ALL)
            chan8 = {3'h0, `MCS_CH_GPIO1} + idx8 - ((step > `MCS_REF2_STEP) ? 8'h01 : 8'h00);
          else
            chan8 = {3'h0, `MCS_CH_GPIO1} + {4'h0, sel} - 8'h01;
          if (((sel == `MCS_SEL_ALL) && (step == `MCS_REF2_STEP)) || (sel == `MCS_SEL_REF2))
            chan8 = {3'h0, `MCS_CH_REF2};
        end
      endcase
      step_target = {((kind == `MCS_KIND_CELLS3) ? step[1:0] : unit8[1:0]), chan8[4:0]};
    end
  endfunction

  reg [3:0]            state_q;
  reg [1:0]            kind_q;
  reg [3:0]            sel_q;
  reg [4:0]            step_q;
  reg [4:0]            steps_q;
  reg [`MCS_US_W-1:0]  limit_us_q;
  reg [`MCS_US_W-1:0]  elapsed_us_q;
  reg [15:0]           presc_q;
  wire [15:0]          code;
  wire                 over;
  wire                 under;
  wire [6:0]           target;
  wire                 sel_ok;
  wire                 accept;
  wire [31:0]          presc_last = CYC_PER_US - 1;

  // Auxiliary selects above the second reference are refused
  assign sel_ok = (cmd_kind == `MCS_KIND_CELLS3) || (cmd_kind == `MCS_KIND_CELLS_AUX) || (cmd_sel <= `MCS_SEL_REF2);
  assign accept = cmd_valid && (state_q == ST_IDLE) && sel_ok;
  assign target = step_target(kind_q, sel_q, step_q);

  mcs_cell_check u_check
  (
    .raw   (conv_raw),
    .uv_th (uv_threshold),
    .ov_th (ov_threshold),
    .code  (code),
    .over  (over),
    .under (under)
  );

  // Microsecond time base; restarted at each command so the total time is measured from receipt
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      presc_q      <= 16'h0000;
      elapsed_us_q <= {`MCS_US_W{1'b0}};
    end
    else if (accept || (busy_q && (presc_q == presc_last[15:0])))
    begin
      presc_q      <= 16'h0000;
      elapsed_us_q <= accept ? {`MCS_US_W{1'b0}} : elapsed_us_q + 1'b1;
    end
    else if (busy_q)
      presc_q <= presc_q + 1'b1;
  end

  // Sequencing state machine
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q          <= ST_IDLE;
      kind_q           <= `MCS_KIND_CELLS3;
      sel_q            <= 4'h0;
      step_q           <= 5'h00;
      steps_q          <= 5'h00;
      limit_us_q       <= {`MCS_US_W{1'b0}};
      busy_q           <= 1'b0;
      done_q           <= 1'b0;
      conv_req_q       <= 1'b0;
      conv_unit_q      <= 2'h0;
      conv_chan_q      <= 5'h00;
      conv_mode_q      <= 3'h0;
      conv_redundant_q <= 1'b0;
    end
    else
    begin
      conv_req_q <= 1'b0;
      done_q     <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (accept)
          begin
            kind_q      <= cmd_kind;
            sel_q       <= cmd_sel;
            conv_mode_q <= cmd_mode;
            step_q      <= 5'h00;
            steps_q     <= step_count(cmd_kind, cmd_sel);
            limit_us_q  <= total_us(cmd_kind, cmd_mode, cmd_sel);
            busy_q      <= 1'b1;
            // Checking only runs on the redundant command with a usable path
            conv_redundant_q <= (cmd_kind == `MCS_KIND_AUX_RED) && (redundancy_path_select <= `MCS_PS_MAX_OK);
            state_q     <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          conv_req_q  <= 1'b1;
          conv_unit_q <= target[6:5];
          conv_chan_q <= target[4:0];
          state_q     <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (conv_ack && (step_q == steps_q - 5'h01))
            state_q <= ST_HOLD;
          else if (conv_ack)
          begin
            step_q  <= step_q + 5'h01;
            state_q <= ST_ISSUE;
          end
        end
        ST_HOLD:
        begin
          // A slow converter can stretch the command, never shorten it
          if (elapsed_us_q >= limit_us_q)
          begin
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Result capture and cell limit flags, written as each channel completes
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      result_valid_q <= 1'b0;
      result_chan_q  <= 5'h00;
      result_data_q  <= 16'h0000;
      ov_flags_q     <= 18'h00000;
      uv_flags_q     <= 18'h00000;
    end
    else
    begin
      result_valid_q <= 1'b0;
      if ((state_q == ST_WAIT) && conv_ack)
      begin
        result_valid_q <= 1'b1;
        result_chan_q  <= conv_chan_q;
        result_data_q  <= code;
        if (conv_chan_q < `MCS_NUM_CELLS)
        begin
          // Flags track the latest reading of each cell
          ov_flags_q[conv_chan_q] <= over;
          uv_flags_q[conv_chan_q] <= under;
        end
      end
    end
  end

endmodule

// [mcs_defines.vh]
// Constants for the measurement command sequencer
`ifndef MCS_DEFINES_VH
`define MCS_DEFINES_VH

// Clock and time base
`define MCS_CLK_PERIOD_NS   50
`define MCS_NS_PER_US       1000
`define MCS_US_W            20

// Command kinds
`define MCS_KIND_CELLS3     2'h0
`define MCS_KIND_AUX        2'h1
`define MCS_KIND_AUX_RED    2'h2
`define MCS_KIND_CELLS_AUX  2'h3

// Channel codes: cells 0..17, auxiliary inputs 18..26, second reference 27
`define MCS_NUM_CELLS       5'h12
`define MCS_CELLS_PER_UNIT  5'h06
`define MCS_CH_GPIO1        5'h12
`define MCS_CH_REF2         5'h1b
`define MCS_NUM_GPIO        4'h9
`define MCS_SEL_ALL         4'h0
`define MCS_SEL_REF2        4'ha
`define MCS_REF2_STEP       5'h05

// Steps per sequence
`define MCS_STEPS_CELLS3    5'h03
`define MCS_STEPS_AUX_ALL   5'h0a
`define MCS_STEPS_AUX_ONE   5'h01
`define MCS_STEPS_CELLS_AUX 5'h14
`define MCS_AUX_SLOT        5'h09
`define MCS_UNITS           5'h03

// Redundancy path selections that enable checking
`define MCS_PS_MAX_OK       2'h1

// Total time, three cells, in microseconds per mode
`define MCS_T1C_M0 20'h000cb
`define MCS_T1C_M1 20'h000e8
`define MCS_T1C_M2 20'h00197
`define MCS_T1C_M3 20'h0020b
`define MCS_T1C_M4 20'h002f4
`define MCS_T1C_M5 20'h004c5
`define MCS_T1C_M6 20'h00868
`define MCS_T1C_M7 20'h08322

// Total time, full auxiliary scan, in microseconds per mode
`define MCS_T10C_M0 20'h00721
`define MCS_T10C_M1 20'h00844
`define MCS_T10C_M2 20'h00f16
`define MCS_T10C_M3 20'h013a1
`define MCS_T10C_M4 20'h01cb9
`define MCS_T10C_M5 20'h02ee7
`define MCS_T10C_M6 20'h05344
`define MCS_T10C_M7 20'h51e8a

// Total time, cells plus two auxiliary inputs, in microseconds per mode
`define MCS_T8C_M0 20'h005e7
`define MCS_T8C_M1 20'h006d0
`define MCS_T8C_M2 20'h00c44
`define MCS_T8C_M3 20'h00fe7
`define MCS_T8C_M4 20'h0172d
`define MCS_T8C_M5 20'h025b9
`define MCS_T8C_M6 20'h042d0
`define MCS_T8C_M7 20'h418a2

`endif

// [mcs_cell_check.v]
// Result clamp and threshold comparison for one conversion result
`timescale 1ns/10ps
`include "mcs_defines.vh"

module mcs_cell_check
(
  // Raw converter reading, two's complement
  input  wire [16:0] raw,
  // Thresholds
  input  wire [15:0] uv_th,
  input  wire [15:0] ov_th,
  // Clamped code and flags
  output wire [15:0] code,
  output wire        over,
  output wire        under
);

  // Negative readings are clamped to zero
  assign code  = raw[16] ? 16'h0000 : raw[15:0];
  // Strict compares on both limits
  assign over  = (code > ov_th);
  assign under = (code < uv_th);

endmodule

// [mcs_conv_model.sv]
// Behavioural converter answering the sequencer's conversion requests
`timescale 1ns/10ps
module mcs_conv_model
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Request from the sequencer
  input  wire logic        conv_req_q,
  input  wire logic [4:0]  conv_chan_q,
  // Scenario controls: answer delay and negative readings
  input  wire logic [7:0]  latency,
  input  wire logic        neg,
  // Answer
  output logic             conv_ack,
  output logic      [16:0] conv_raw
);
  logic       pend_q;
  logic [7:0] cnt_q;
  logic [4:0] chan_q;
  // One conversion outstanding; the reading line toggles outside an answer so stale data never matches
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      pend_q   <= 1'b0;
      cnt_q    <= 8'h00;
      chan_q   <= 5'h00;
      conv_ack <= 1'b0;
      conv_raw <= 17'h00000;
    end
    else
    begin
      conv_ack <= 1'b0;
      conv_raw <= ~conv_raw;
      if (conv_req_q)
      begin
        pend_q <= 1'b1;
        cnt_q  <= latency;
        chan_q <= conv_chan_q;
      end
      else if (pend_q && cnt_q <= 8'h01)
      begin
        pend_q   <= 1'b0;
        conv_ack <= 1'b1;
        conv_raw <= neg ? 17'h1fff0 : {1'b0, 16'h1000 + {chan_q, 11'h000}};
      end
      else if (pend_q)
        cnt_q <= cnt_q - 8'h01;
    end
endmodule

// [mcs_sequencer_asserts.sv]
// Port assertions for the measurement command sequencer
`timescale 1ns/10ps
module mcs_check
#(
  parameter CYC_PER_US = 20
)
(
  // Clock, reset and command
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_sel,
  input wire logic [15:0] uv_threshold,
  input wire logic [15:0] ov_threshold,
  // Converter side
  input wire logic        conv_req_q,
  input wire logic [1:0]  conv_unit_q,
  input wire logic [4:0]  conv_chan_q,
  input wire logic        conv_ack,
  input wire logic [16:0] conv_raw,
  // Results and status
  input wire logic        result_valid_q,
  input wire logic [15:0] result_data_q,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic [17:0] ov_flags_q,
  input wire logic [17:0] uv_flags_q
);
  // Shortest total of any command, with margin for the start-up cycles
  localparam int TMIN = 200 * CYC_PER_US;
  int unsigned cyc_q;
  logic [4:0]  last_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Busy cycle count and last requested channel of the running command
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      cyc_q  <= 0;
      last_q <= 5'h1f;
    end
    else
    begin
      cyc_q <= busy_q ? cyc_q + 1 : 0;
      if (done_q)
        last_q <= 5'h1f;
      else if (conv_req_q)
        last_q <= conv_chan_q;
    end
  sequence s_accept;
    cmd_valid && !busy_q && cmd_sel <= 4'h5;
  endsequence
  sequence s_issue;
    busy_q ##1 conv_req_q;
  endsequence
  sequence s_after_gpio5;
    conv_req_q && last_q == 5'h16;
  endsequence
  a_cmd_starts: assert property (s_accept |=> s_issue) else $error("command did not start");
  a_idle_no_req: assert property (!busy_q |-> !conv_req_q) else $error("request while idle");
  a_busy_ends: assert property ($fell(busy_q) |-> done_q) else $error("busy fell without done");
  a_result_code: assert property (conv_ack |=> result_valid_q &&
    result_data_q == ($past(conv_raw[16]) ? 16'h0000 : $past(conv_raw[15:0]))) else $error("bad result");
  a_ov_flag: assert property (conv_ack && conv_chan_q < 5'h12 |=>
    ov_flags_q[$past(conv_chan_q)] == (result_data_q > $past(ov_threshold))) else $error("bad ov flag");
  a_uv_flag: assert property (conv_ack && conv_chan_q < 5'h12 |=>
    uv_flags_q[$past(conv_chan_q)] == (result_data_q < $past(uv_threshold))) else $error("bad uv flag");
  a_aux_unit: assert property (conv_req_q && conv_chan_q > 5'h11 |-> conv_unit_q == 2'h0) else $error("aux unit");
  a_ref2_order: assert property (s_after_gpio5 |-> conv_chan_q == 5'h1b) else $error("ref2 order");
  a_no_early: assert property (done_q |-> cyc_q >= TMIN) else $error("done too early");
endmodule

// [mcs_sequencer_test.sv]
// Self-checking testbench for the measurement command sequencer
`timescale 1ns/10ps
module mcs_sequencer_test;
  logic        clock = 0, nrst = 0, cmd_valid = 0, neg = 0, conv_ack, red_seen;
  logic [1:0]  cmd_kind = 0, ps = 0, conv_unit_q;
  logic [2:0]  cmd_mode = 0, conv_mode_q;
  logic [3:0]  cmd_sel = 0;
  logic [15:0] uv_th = 16'h3000, ov_th = 16'h7000, result_data_q;
  logic [7:0]  lat = 8'h01;
  logic [16:0] conv_raw;
  logic        conv_req_q, conv_redundant_q, result_valid_q, busy_q, done_q;
  logic [4:0]  conv_chan_q, result_chan_q;
  logic [17:0] ov_flags_q, uv_flags_q;
  logic [6:0]  reqs[$];
  logic [20:0] ress[$];
  int          req_t[$];
  int          cyc = 0, n_fail = 0, checks_done = 0;
  int          t1c[8] = '{203, 232, 407, 523, 756, 1221, 2152, 33570};
  mcs_sequencer #(.CYC_PER_US(1)) mcs_sequencer_inst (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_mode(cmd_mode), .cmd_sel(cmd_sel), .uv_threshold(uv_th), .ov_threshold(ov_th),
    .redundancy_path_select(ps), .conv_req_q(conv_req_q), .conv_unit_q(conv_unit_q), .conv_chan_q(conv_chan_q),
    .conv_mode_q(conv_mode_q), .conv_redundant_q(conv_redundant_q), .conv_ack(conv_ack), .conv_raw(conv_raw),
    .result_valid_q(result_valid_q), .result_chan_q(result_chan_q), .result_data_q(result_data_q),
    .busy_q(busy_q), .done_q(done_q), .ov_flags_q(ov_flags_q), .uv_flags_q(uv_flags_q));
  mcs_conv_model mcs_conv_model_inst (.clock(clock), .nrst(nrst), .conv_req_q(conv_req_q),
    .conv_chan_q(conv_chan_q), .latency(lat), .neg(neg), .conv_ack(conv_ack), .conv_raw(conv_raw));
  // Clock
  initial
    forever #25 clock = ~clock;
  // Record requests and results; a hang ends the run
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (conv_req_q === 1'b1)
    begin
      reqs.push_back({conv_unit_q, conv_chan_q});
      req_t.push_back(cyc);
      red_seen = conv_redundant_q;
    end
    if (result_valid_q === 1'b1)
      ress.push_back({result_chan_q, result_data_q});
    if (cyc > 70000)
    begin
      n_fail++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Completion time may trail the total by the start-up cycles only
  task chk_time(input int total, input int n);
    checks_done++;
    if (n < total || n > total + 4)
    begin
      n_fail++;
      $display("wrong value cycles expected %0d seen %0d", total, n);
    end
  endtask
  function automatic logic [6:0] ent(input int u, input int c);
    return {u[1:0], c[4:0]};
  endfunction
  // One command; poke re-strobes it while busy, which must be ignored
  task run(input int k, input int m, input int s, input int poke, output int n);
    reqs.delete();
    ress.delete();
    req_t.delete();
    cmd_kind = k[1:0];
    cmd_mode = m[2:0];
    cmd_sel = s[3:0];
    cmd_valid = 1;
    @(negedge clock);
    cmd_valid = 0;
    n = 1;
    while (done_q !== 1'b1 && n < 40000)
    begin
      @(negedge clock);
      n++;
      cmd_valid = (n == poke);
    end
  endtask
  task chk_seq(input logic [6:0] e[$]);
    chk("request count", e.size(), reqs.size());
    foreach (e[i])
    begin
      chk("request", e[i], reqs[i]);
      chk("result", {e[i][4:0], neg ? 16'h0000 : 16'h1000 + {e[i][4:0], 11'h000}}, ress[i]);
    end
  endtask
  task t_cells3;
    int n;
    logic [6:0] e[$];
    for (int m = 0; m < 8; m++)
    begin
      run(0, m, m % 6, 0, n);
      e = {ent(0, m % 6), ent(1, m % 6 + 6), ent(2, m % 6 + 12)};
      chk_time(t1c[m], n);
      chk_seq(e);
      chk("mode", m, conv_mode_q);
    end
    chk("ov flags", 18'h3e000, ov_flags_q);
    chk("uv flags", 18'h0000f, uv_flags_q);
    $display("test three cells finished");
  endtask
  task t_combined;
    int n;
    logic [6:0] e[$];
    for (int i = 0; i < 18; i++)
    begin
      if (i == 9)
        e = {e, ent(0, 18), ent(0, 19)};
      e.push_back(ent(i % 3, i / 3 + 6 * (i % 3)));
    end
    // Fast mode, then normal mode, so more than one row of the combined table is used
    for (int m = 0; m < 3; m += 2)
    begin
      run(3, m, 0, 0, n);
      chk_time(m == 0 ? 1511 : 3140, n);
      chk_seq(e);
      if (m == 0)
        chk("skew", 1, req_t[9] - req_t[0] <= 194);
    end
    chk("ov flags", 18'h3e000, ov_flags_q);
    $display("test combined finished");
  endtask
  task t_aux;
    int n;
    logic [6:0] e[$];
    lat = 8'h28;
    e = {ent(0, 18), ent(0, 19), ent(0, 20), ent(0, 21), ent(0, 22), ent(0, 27)};
    e = {e, ent(0, 23), ent(0, 24), ent(0, 25), ent(0, 26)};
    run(1, 0, 0, 0, n);
    chk_time(1825, n);
    chk_seq(e);
    chk("redundant", 0, red_seen);
    ps = 2'h1;
    run(2, 0, 0, 0, n);
    chk_time(1825, n);
    chk_seq(e);
    chk("redundant", 1, red_seen);
    run(2, 2, 0, 0, n);
    chk_time(3862, n);
    chk_seq(e);
    lat = 8'h01;
    for (int s = 1; s <= 10; s++)
    begin
      run(1, 0, s, 0, n);
      e = {ent(0, s == 10 ? 27 : 17 + s)};
      chk_time(203, n);
      chk_seq(e);
    end
    $display("test auxiliary finished");
  endtask
  task t_refuse_neg;
    int n;
    logic [6:0] e[$];
    // An auxiliary select above the reference is refused: no busy and no request
    reqs.delete();
    cmd_kind = 2'h1;
    cmd_sel = 4'hb;
    cmd_valid = 1;
    repeat (3) @(negedge clock);
    cmd_valid = 0;
    @(negedge clock);
    chk("busy after bad select", 0, busy_q);
    chk("requests after bad select", 0, reqs.size());
    neg = 1;
    run(0, 0, 2, 20, n);
    e = {ent(0, 2), ent(1, 8), ent(2, 14)};
    chk_time(203, n);
    chk_seq(e);
    chk("uv flags", 18'h0410f, uv_flags_q);
    chk("ov flags", 18'h3a000, ov_flags_q);
    neg = 0;
    $display("test refusal and clamp finished");
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(negedge clock);
    chk("busy in reset", 0, busy_q);
    chk("flags in reset", 0, {ov_flags_q, uv_flags_q});
    nrst = 1;
    @(negedge clock);
    t_cells3;
    t_combined;
    t_aux;
    t_refuse_neg;
    stop_test;
  end
endmodule
bind mcs_sequencer mcs_check #(.CYC_PER_US(CYC_PER_US)) mcs_check_inst (.clock(clock), .nrst(nrst),
  .cmd_valid(cmd_valid), .cmd_sel(cmd_sel), .uv_threshold(uv_threshold), .ov_threshold(ov_threshold),
  .conv_req_q(conv_req_q), .conv_unit_q(conv_unit_q), .conv_chan_q(conv_chan_q), .conv_ack(conv_ack),
  .conv_raw(conv_raw), .result_valid_q(result_valid_q), .result_data_q(result_data_q), .busy_q(busy_q),
  .done_q(done_q), .ov_flags_q(ov_flags_q), .uv_flags_q(uv_flags_q));
